// ==== hdl/skb_exec.sv ====
// execution of skip, branch, call, return and shadow save/restore instructions
`default_nettype none
module skb_exec
    import skb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ins_valid,
    output logic o_ins_ready,
    input wire skb_op_e i_op,
    input wire logic [DATA_W-1:0] i_imm,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [BIT_W-1:0] i_bit,
    input wire logic [TARGET_W-1:0] i_target,
    input wire logic i_osc_access,
    input wire logic [DATA_W-1:0] i_acc,
    input wire logic [DATA_W-1:0] i_mem_rdata,
    input wire logic [DATA_W-1:0] i_bank0_rdata,
    input wire logic [PAGE_W-1:0] i_rom_page_select_bits,
    input wire logic [PC_W-1:0] i_pc_next,
    input wire logic [PC_W-1:0] i_stack_top,
    input wire logic [WREG_W-1:0] i_wreg,
    output logic o_acc_we,
    output logic [DATA_W-1:0] o_acc_wdata,
    output logic o_mem_we,
    output logic o_mem_bank0,
    output logic [ADDR_W-1:0] o_mem_addr,
    output logic [DATA_W-1:0] o_mem_wdata,
    output logic o_flag_we,
    output logic o_zero_flag,
    output logic o_carry_flag,
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_value,
    output logic o_stack_push,
    output logic [PC_W-1:0] o_push_data,
    output logic o_stack_pop,
    output logic o_gie_set,
    output logic o_wreg_restore,
    output logic [WREG_W-1:0] o_wreg_data,
    output logic o_discard,
    output logic o_skip_pending
);
    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [DATA_W-1:0] bit_force(input logic [DATA_W-1:0] v,
                                                   input logic [BIT_W-1:0] b,
                                                   input logic val);
        logic [DATA_W-1:0] r;
        r = v;
        r[b] = val;
        return r;
    endfunction : bit_force

    function automatic logic [CNT_W-1:0] add_osc(input logic [CNT_W-1:0] base,
                                                input logic osc);
        return osc ? base + CYC_OSC_EXTRA : base;
    endfunction : add_osc

    ////////////////////////////////////////////////////////////////////////
    // state
    skb_state_e state_ff, nxt_state;
    logic [CNT_W-1:0] wait_ff, nxt_wait;
    logic skip_ff, nxt_skip;
    skb_out_s out_ff, nxt_out;
    logic take;
    logic [DATA_W-1:0] inc_val;
    logic [DATA_W-1:0] dec_val;
    logic [DATA_W-1:0] cmp_opnd;
    logic [DATA_W:0] cmp_diff;
    logic [CNT_W-1:0] cycles;
    logic do_skip;

    skb_shadow_if sh ();

    skb_shadow u_shadow (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .sh(sh)
    );

    assign o_ins_ready = (state_ff == ST_IDLE);
    assign take = i_ins_valid && o_ins_ready;
    assign sh.save_data = i_wreg;
    assign sh.save = take && !skip_ff && (i_op == OP_WREG_SAVE);

    assign inc_val = i_mem_rdata + 8'h01;
    assign dec_val = i_mem_rdata - 8'h01;
    assign cmp_opnd = (i_op == OP_COMPARE_SKIP_EQUAL_IMM) ? i_imm : i_mem_rdata;
    assign cmp_diff = {1'b0, i_acc} - {1'b0, cmp_opnd};

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        nxt_state = state_ff;
        nxt_wait = wait_ff;
        nxt_skip = skip_ff;
        nxt_out = OUT_IDLE;
        nxt_out.acc_wdata = out_ff.acc_wdata;
        nxt_out.mem_addr = out_ff.mem_addr;
        nxt_out.mem_wdata = out_ff.mem_wdata;
        nxt_out.mem_bank0 = out_ff.mem_bank0;
        nxt_out.zero_flag = out_ff.zero_flag;
        nxt_out.carry_flag = out_ff.carry_flag;
        nxt_out.pc_value = out_ff.pc_value;
        nxt_out.push_data = out_ff.push_data;
        cycles = CYC_SINGLE;
        do_skip = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (take && skip_ff) begin
                    nxt_skip = 1'b0;
                    nxt_out.discard = 1'b1;
                end else if (take) begin
                    nxt_out.mem_addr = i_addr;
                    nxt_out.mem_bank0 = 1'b0;
                    case (i_op)
                        OP_COMPARE_SKIP_EQUAL_IMM, OP_COMPARE_SKIP_EQUAL_MEM: begin
                            nxt_out.flag_we = 1'b1;
                            nxt_out.zero_flag = (cmp_diff[DATA_W-1:0] == 8'h00);
                            nxt_out.carry_flag = ~cmp_diff[DATA_W];
                            do_skip = (i_acc == cmp_opnd);
                        end
                        OP_INCREMENT_TO_ACC_SKIP_ZERO: begin
                            nxt_out.acc_we = 1'b1;
                            nxt_out.acc_wdata = inc_val;
                            do_skip = (inc_val == 8'h00);
                        end
                        OP_INCREMENT_MEM_SKIP_ZERO: begin
                            nxt_out.mem_we = 1'b1;
                            nxt_out.mem_wdata = inc_val;
                            do_skip = (inc_val == 8'h00);
                        end
                        OP_DECREMENT_TO_ACC_SKIP_ZERO: begin
                            nxt_out.acc_we = 1'b1;
                            nxt_out.acc_wdata = dec_val;
                            do_skip = (dec_val == 8'h00);
                        end
                        OP_DECREMENT_MEM_SKIP_ZERO: begin
                            nxt_out.mem_we = 1'b1;
                            nxt_out.mem_wdata = dec_val;
                            do_skip = (dec_val == 8'h00);
                        end
                        OP_BIT_CLEAR_TEST_SKIP: begin
                            do_skip = ~i_mem_rdata[i_bit];
                        end
                        OP_BIT_SET_TEST_SKIP: begin
                            do_skip = i_mem_rdata[i_bit];
                        end
                        OP_BANK0_BIT_CLEAR_TEST_SKIP: begin
                            do_skip = ~i_bank0_rdata[i_bit];
                        end
                        OP_BANK0_BIT_SET_TEST_SKIP: begin
                            do_skip = i_bank0_rdata[i_bit];
                        end
                        OP_BANK0_BIT_CLEAR, OP_BANK0_BIT_SET: begin
                            nxt_out.mem_we = 1'b1;
                            nxt_out.mem_bank0 = 1'b1;
                            nxt_out.mem_wdata = bit_force(i_bank0_rdata, i_bit, i_op == OP_BANK0_BIT_SET);
                        end
                        OP_JUMP_INSTRUCTION, OP_CALL: begin
                            cycles = CYC_BRANCH;
                            nxt_out.pc_load = 1'b1;
                            nxt_out.pc_value = {i_rom_page_select_bits, i_target};
                            if (i_op == OP_CALL) begin
                                nxt_out.stack_push = 1'b1;
                                nxt_out.push_data = i_pc_next;
                            end
                        end
                        OP_RETURN, OP_INTERRUPT_RETURN: begin
                            cycles = CYC_BRANCH;
                            nxt_out.pc_load = 1'b1;
                            nxt_out.pc_value = i_stack_top;
                            nxt_out.stack_pop = 1'b1;
                            nxt_out.gie_set = (i_op == OP_INTERRUPT_RETURN);
                        end
                        OP_WREG_RESTORE: begin
                            nxt_out.wreg_restore = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                    nxt_skip = do_skip;
                    cycles = add_osc(cycles, i_osc_access);
                    if (cycles > CYC_SINGLE) begin
                        nxt_state = ST_WAIT;
                        nxt_wait = cycles - CYC_SINGLE - 2'h1;
                    end
                end
            end
            ST_WAIT: begin
                if (wait_ff == 2'h0) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_wait = wait_ff - 2'h1;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_ff <= ST_IDLE;
            wait_ff <= 2'h0;
            skip_ff <= 1'b0;
            out_ff <= OUT_IDLE;
        end else begin
            state_ff <= nxt_state;
            wait_ff <= nxt_wait;
            skip_ff <= nxt_skip;
            out_ff <= nxt_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_acc_we = out_ff.acc_we;
    assign o_acc_wdata = out_ff.acc_wdata;
    assign o_mem_we = out_ff.mem_we;
    assign o_mem_bank0 = out_ff.mem_bank0;
    assign o_mem_addr = out_ff.mem_addr;
    assign o_mem_wdata = out_ff.mem_wdata;
    assign o_flag_we = out_ff.flag_we;
    assign o_zero_flag = out_ff.zero_flag;
    assign o_carry_flag = out_ff.carry_flag;
    assign o_pc_load = out_ff.pc_load;
    assign o_pc_value = out_ff.pc_value;
    assign o_stack_push = out_ff.stack_push;
    assign o_push_data = out_ff.push_data;
    assign o_stack_pop = out_ff.stack_pop;
    assign o_gie_set = out_ff.gie_set;
    assign o_wreg_restore = out_ff.wreg_restore;
    assign o_wreg_data = sh.shadow_data;
    assign o_discard = out_ff.discard;
    assign o_skip_pending = skip_ff;
endmodule : skb_exec
`default_nettype wire

// ==== hdl/skb_pkg.sv ====
// constants, types and opcode set for the skip/branch/call execution block
`default_nettype none
package skb_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned PC_W = 16;
    localparam int unsigned TARGET_W = 14;
    localparam int unsigned PAGE_W = 2;
    localparam int unsigned BIT_W = 3;
    localparam logic [ADDR_W-1:0] WREG_BASE = 8'h80;
    localparam int unsigned WREG_COUNT = 8;
    localparam int unsigned WREG_W = DATA_W * WREG_COUNT;
    localparam int unsigned CNT_W = 2;
    localparam logic [CNT_W-1:0] CYC_SINGLE = 2'h1;
    localparam logic [CNT_W-1:0] CYC_BRANCH = 2'h2;
    localparam logic [CNT_W-1:0] CYC_OSC_EXTRA = 2'h1;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_COMPARE_SKIP_EQUAL_IMM,
        OP_COMPARE_SKIP_EQUAL_MEM,
        OP_INCREMENT_TO_ACC_SKIP_ZERO,
        OP_INCREMENT_MEM_SKIP_ZERO,
        OP_DECREMENT_TO_ACC_SKIP_ZERO,
        OP_DECREMENT_MEM_SKIP_ZERO,
        OP_BIT_CLEAR_TEST_SKIP,
        OP_BIT_SET_TEST_SKIP,
        OP_BANK0_BIT_CLEAR_TEST_SKIP,
        OP_BANK0_BIT_SET_TEST_SKIP,
        OP_BANK0_BIT_CLEAR,
        OP_BANK0_BIT_SET,
        OP_JUMP_INSTRUCTION,
        OP_CALL,
        OP_RETURN,
        OP_INTERRUPT_RETURN,
        OP_WREG_SAVE,
        OP_WREG_RESTORE
    } skb_op_e;

    typedef enum logic {
        ST_IDLE,
        ST_WAIT
    } skb_state_e;

    typedef struct packed {
        logic acc_we;
        logic [DATA_W-1:0] acc_wdata;
        logic mem_we;
        logic mem_bank0;
        logic [ADDR_W-1:0] mem_addr;
        logic [DATA_W-1:0] mem_wdata;
        logic flag_we;
        logic zero_flag;
        logic carry_flag;
        logic pc_load;
        logic [PC_W-1:0] pc_value;
        logic stack_push;
        logic [PC_W-1:0] push_data;
        logic stack_pop;
        logic gie_set;
        logic wreg_restore;
        logic discard;
    } skb_out_s;

    localparam skb_out_s OUT_IDLE = '0;
endpackage : skb_pkg
`default_nettype wire

// ==== hdl/skb_shadow_if.sv ====
// link between the executer and the working-register shadow store
`default_nettype none
interface skb_shadow_if;
    import skb_pkg::*;
    logic save;
    logic [WREG_W-1:0] save_data;
    logic [WREG_W-1:0] shadow_data;
    modport ctrl (output save, output save_data, input shadow_data);
    modport store (input save, input save_data, output shadow_data);
endinterface : skb_shadow_if
`default_nettype wire

// ==== hdl/skb_shadow.sv ====
// shadow buffers for working registers 080H-087H
`default_nettype none
module skb_shadow
    import skb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    skb_shadow_if.store sh
);
    logic [DATA_W-1:0] buf_ff [WREG_COUNT];
    logic [DATA_W-1:0] nxt_buf [WREG_COUNT];

    always_comb begin
        for (int i = 0; i < WREG_COUNT; i++) begin
            nxt_buf[i] = buf_ff[i];
            if (sh.save) begin
                nxt_buf[i] = sh.save_data[i*DATA_W +: DATA_W];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        for (int i = 0; i < WREG_COUNT; i++) begin
            if (i_rst) begin
                buf_ff[i] <= 8'h00;
            end else begin
                buf_ff[i] <= nxt_buf[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < WREG_COUNT; i++) begin
            sh.shadow_data[i*DATA_W +: DATA_W] = buf_ff[i];
        end
    end
endmodule : skb_shadow
`default_nettype wire

// ==== tb/skb_exec_sva.sv ====
// assertion checker for the skip/branch/call executer
`default_nettype none
module skb_exec_sva
    import skb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ins_valid,
    input wire logic o_ins_ready,
    input wire skb_op_e i_op,
    input wire logic [DATA_W-1:0] i_imm,
    input wire logic [BIT_W-1:0] i_bit,
    input wire logic [TARGET_W-1:0] i_target,
    input wire logic i_osc_access,
    input wire logic [DATA_W-1:0] i_acc,
    input wire logic [DATA_W-1:0] i_mem_rdata,
    input wire logic [DATA_W-1:0] i_bank0_rdata,
    input wire logic [PAGE_W-1:0] i_rom_page_select_bits,
    input wire logic [PC_W-1:0] i_pc_next,
    input wire logic [PC_W-1:0] i_stack_top,
    input wire logic o_mem_we,
    input wire logic o_mem_bank0,
    input wire logic [DATA_W-1:0] o_mem_wdata,
    input wire logic o_flag_we,
    input wire logic o_zero_flag,
    input wire logic o_carry_flag,
    input wire logic o_pc_load,
    input wire logic [PC_W-1:0] o_pc_value,
    input wire logic o_stack_push,
    input wire logic [PC_W-1:0] o_push_data,
    input wire logic o_stack_pop,
    input wire logic o_gie_set,
    input wire logic o_discard,
    input wire logic o_skip_pending
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic tk = i_ins_valid && o_ins_ready && !o_skip_pending;
    wire logic ds = i_ins_valid && o_ins_ready && o_skip_pending;
    wire logic b0bit = i_bank0_rdata[i_bit];
    wire logic br = i_op inside {OP_JUMP_INSTRUCTION, OP_CALL, OP_RETURN, OP_INTERRUPT_RETURN};
    sequence s_one_wait; !o_ins_ready ##1 o_ins_ready; endsequence
    sequence s_two_wait; !o_ins_ready [*2] ##1 o_ins_ready; endsequence
    ////////////////////////////////////////////////////////////////
    property p_jump; tk && i_op == OP_JUMP_INSTRUCTION && !i_osc_access |=> o_pc_load
        && o_pc_value == {$past(i_rom_page_select_bits), $past(i_target)} ##0 s_one_wait; endproperty
    a_jump: assert property (p_jump) else $error("jump target or timing wrong");
    property p_osc; tk && br && i_osc_access |=> s_two_wait; endproperty
    a_osc: assert property (p_osc) else $error("oscillator extra cycle missing");
    property p_osc1; tk && !br && i_osc_access |=> s_one_wait; endproperty
    a_osc1: assert property (p_osc1) else $error("oscillator extra cycle missing on single");
    property p_dec; tk && i_op == OP_DECREMENT_MEM_SKIP_ZERO |=> o_mem_we && !o_flag_we && !o_mem_bank0
        && o_mem_wdata == 8'($past(i_mem_rdata) - 8'h01) && o_skip_pending == (o_mem_wdata == 8'h00); endproperty
    a_dec: assert property (p_dec) else $error("decrement skip wrong");
    property p_call; tk && i_op == OP_CALL |=> o_stack_push && o_pc_load && o_push_data == $past(i_pc_next);
    endproperty
    a_call: assert property (p_call) else $error("call push wrong");
    property p_iret; tk && i_op == OP_INTERRUPT_RETURN |=> o_gie_set && o_stack_pop
        && o_pc_value == $past(i_stack_top); endproperty
    a_iret: assert property (p_iret) else $error("interrupt return wrong");
    property p_cmp; tk && i_op == OP_COMPARE_SKIP_EQUAL_IMM |=> o_flag_we && o_skip_pending == o_zero_flag
        && o_zero_flag == ($past(i_acc) == $past(i_imm)) && o_carry_flag == ($past(i_acc) >= $past(i_imm));
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare flags wrong");
    property p_inc; tk && i_op == OP_INCREMENT_MEM_SKIP_ZERO |=> o_mem_we && !o_flag_we
        && o_mem_wdata == 8'($past(i_mem_rdata) + 8'h01) && o_skip_pending == (o_mem_wdata == 8'h00); endproperty
    a_inc: assert property (p_inc) else $error("increment skip wrong");
    property p_b0test; tk && i_op == OP_BANK0_BIT_CLEAR_TEST_SKIP |=> o_skip_pending == !$past(b0bit);
    endproperty
    a_b0test: assert property (p_b0test) else $error("bank0 bit test wrong");
    property p_b0set; tk && i_op == OP_BANK0_BIT_SET |=> o_mem_we && o_mem_bank0 && !o_flag_we
        && o_mem_wdata == ($past(i_bank0_rdata) | (8'h01 << $past(i_bit))); endproperty
    a_b0set: assert property (p_b0set) else $error("bank0 bit set wrong");
    property p_drop; ds |=> o_discard && o_ins_ready && !o_pc_load && !o_mem_we && !o_flag_we
        && !o_skip_pending; endproperty
    a_drop: assert property (p_drop) else $error("skipped instruction had effects");
endmodule : skb_exec_sva
bind skb_exec skb_exec_sva u_skb_exec_sva (.i_clk, .i_rst, .i_ins_valid, .o_ins_ready, .i_op, .i_imm, .i_bit,
    .i_target, .i_osc_access, .i_acc, .i_mem_rdata, .i_bank0_rdata, .i_rom_page_select_bits, .i_pc_next,
    .i_stack_top, .o_mem_we, .o_mem_bank0, .o_mem_wdata, .o_flag_we, .o_zero_flag, .o_carry_flag, .o_pc_load,
    .o_pc_value, .o_stack_push, .o_push_data, .o_stack_pop, .o_gie_set, .o_discard, .o_skip_pending);
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench for the skip/branch/call executer
`default_nettype none
module testbench
    import skb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_rst = 1, i_ins_valid = 0, i_osc_access = 0;
    skb_op_e i_op = OP_NOP;
    logic [7:0] i_imm = 0, i_addr = 0, i_acc = 0, i_mem_rdata = 0, i_bank0_rdata = 0;
    logic [2:0] i_bit = 0;
    logic [13:0] i_target = 0;
    logic [1:0] i_rom_page_select_bits = 0;
    logic [15:0] i_pc_next = 0, i_stack_top = 0, o_pc_value, o_push_data;
    logic [63:0] i_wreg = 0, o_wreg_data, sv = 0;
    logic o_ins_ready, o_acc_we, o_mem_we, o_mem_bank0, o_flag_we, o_zero_flag, o_carry_flag, o_pc_load;
    logic o_stack_push, o_stack_pop, o_gie_set, o_wreg_restore, o_discard, o_skip_pending, pend = 0;
    logic [7:0] o_acc_wdata, o_mem_addr, o_mem_wdata;
    int seed = 59238, mismatches = 0, n_tests = 0;
    wire logic [16:0] mw = {o_mem_bank0, o_mem_addr, o_mem_wdata};
    wire logic [8:0] pl = {o_acc_we, o_mem_we, o_flag_we, o_pc_load, o_stack_push, o_stack_pop, o_gie_set,
        o_wreg_restore, o_discard};
    skb_exec u_skb_exec (.i_clk, .i_rst, .i_ins_valid, .o_ins_ready, .i_op, .i_imm, .i_addr, .i_bit, .i_target,
        .i_osc_access, .i_acc, .i_mem_rdata, .i_bank0_rdata, .i_rom_page_select_bits, .i_pc_next, .i_stack_top,
        .i_wreg, .o_acc_we, .o_acc_wdata, .o_mem_we, .o_mem_bank0, .o_mem_addr, .o_mem_wdata, .o_flag_we,
        .o_zero_flag, .o_carry_flag, .o_pc_load, .o_pc_value, .o_stack_push, .o_push_data, .o_stack_pop,
        .o_gie_set, .o_wreg_restore, .o_wreg_data, .o_discard, .o_skip_pending);
    always #5 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////
    function automatic logic [8:0] fx_pulses(input skb_op_e op);
        case (op)
            OP_COMPARE_SKIP_EQUAL_IMM, OP_COMPARE_SKIP_EQUAL_MEM: return 9'h040;
            OP_INCREMENT_TO_ACC_SKIP_ZERO, OP_DECREMENT_TO_ACC_SKIP_ZERO: return 9'h100;
            OP_INCREMENT_MEM_SKIP_ZERO, OP_DECREMENT_MEM_SKIP_ZERO,
            OP_BANK0_BIT_CLEAR, OP_BANK0_BIT_SET: return 9'h080;
            OP_JUMP_INSTRUCTION: return 9'h020;
            OP_CALL: return 9'h030;
            OP_RETURN: return 9'h028;
            OP_INTERRUPT_RETURN: return 9'h02c;
            OP_WREG_RESTORE: return 9'h002;
            default: return 9'h000;
        endcase
    endfunction : fx_pulses
    function automatic logic fx_skip(input skb_op_e op);
        case (op)
            OP_COMPARE_SKIP_EQUAL_IMM: return i_acc == i_imm;
            OP_COMPARE_SKIP_EQUAL_MEM: return i_acc == i_mem_rdata;
            OP_INCREMENT_TO_ACC_SKIP_ZERO, OP_INCREMENT_MEM_SKIP_ZERO: return i_mem_rdata == 8'hff;
            OP_DECREMENT_TO_ACC_SKIP_ZERO, OP_DECREMENT_MEM_SKIP_ZERO: return i_mem_rdata == 8'h01;
            OP_BIT_CLEAR_TEST_SKIP: return !i_mem_rdata[i_bit];
            OP_BIT_SET_TEST_SKIP: return i_mem_rdata[i_bit];
            OP_BANK0_BIT_CLEAR_TEST_SKIP: return !i_bank0_rdata[i_bit];
            OP_BANK0_BIT_SET_TEST_SKIP: return i_bank0_rdata[i_bit];
            default: return 1'b0;
        endcase
    endfunction : fx_skip
    function automatic int fx_busy(input skb_op_e op, input logic osc, input logic skp);
        if (skp) return 0;
        return int'(op inside {OP_JUMP_INSTRUCTION, OP_CALL, OP_RETURN, OP_INTERRUPT_RETURN}) + int'(osc);
    endfunction : fx_busy
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // called at a rising edge, operands already scheduled
    task automatic do_ins(input skb_op_e op, input logic osc);
        int n;
        logic skp;
        logic [7:0] opnd;
        skp = pend;
        n = 0;
        i_ins_valid <= 1'b1;
        i_op <= op;
        i_osc_access <= osc;
        @(posedge i_clk);
        i_ins_valid <= 1'b0;
        #1;
        opnd = (op == OP_COMPARE_SKIP_EQUAL_IMM) ? i_imm : i_mem_rdata;
        chk("pulses", skp ? 9'h001 : fx_pulses(op), pl);
        if (!skp && op == OP_WREG_SAVE) sv = i_wreg;
        if (!skp) case (op)
            OP_COMPARE_SKIP_EQUAL_IMM, OP_COMPARE_SKIP_EQUAL_MEM:
                chk("flags", {i_acc == opnd, i_acc >= opnd}, {o_zero_flag, o_carry_flag});
            OP_INCREMENT_TO_ACC_SKIP_ZERO: chk("acc", 8'(i_mem_rdata + 8'h01), o_acc_wdata);
            OP_DECREMENT_TO_ACC_SKIP_ZERO: chk("acc", 8'(i_mem_rdata - 8'h01), o_acc_wdata);
            OP_INCREMENT_MEM_SKIP_ZERO: chk("mem", {1'b0, i_addr, 8'(i_mem_rdata + 8'h01)}, mw);
            OP_DECREMENT_MEM_SKIP_ZERO: chk("mem", {1'b0, i_addr, 8'(i_mem_rdata - 8'h01)}, mw);
            OP_BANK0_BIT_CLEAR: chk("mem", {1'b1, i_addr, i_bank0_rdata & ~(8'h01 << i_bit)}, mw);
            OP_BANK0_BIT_SET: chk("mem", {1'b1, i_addr, i_bank0_rdata | (8'h01 << i_bit)}, mw);
            OP_JUMP_INSTRUCTION: chk("pc", {i_rom_page_select_bits, i_target}, o_pc_value);
            OP_CALL: chk("call", {i_pc_next, i_rom_page_select_bits, i_target}, {o_push_data, o_pc_value});
            OP_RETURN, OP_INTERRUPT_RETURN: chk("pc", i_stack_top, o_pc_value);
            OP_WREG_SAVE, OP_WREG_RESTORE: chk("shadow", sv, o_wreg_data);
            default: ;
        endcase
        pend = skp ? 1'b0 : fx_skip(op);
        chk("pending", pend, o_skip_pending);
        while (!o_ins_ready && n < 4) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("busy", fx_busy(op, osc, skp), n);
        if (n == 4) begin
            mismatches++;
            report_and_stop();
        end
    endtask : do_ins
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        skb_op_e op;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int k = 0; k < 400; k++) begin
            r = $random(seed);
            op = skb_op_e'(5'(r[31:24] % 19));
            if (k < 19) op = skb_op_e'(5'(k));
            @(posedge i_clk);
            i_acc <= r[7:0];
            i_imm <= r[8] ? r[7:0] : r[15:8];
            i_mem_rdata <= r[9] ? (r[10] ? 8'hff : 8'h01) : (r[11] ? r[7:0] : r[23:16]);
            i_bank0_rdata <= r[23:16] ^ 8'h5a;
            i_bit <= r[14:12];
            i_addr <= r[31:24];
            i_target <= r[13:0];
            i_rom_page_select_bits <= r[17:16];
            i_pc_next <= r[31:16];
            i_stack_top <= r[15:0] ^ 16'ha5c3;
            i_wreg <= {r, ~r ^ {24'h0, 8'(k)}};
            do_ins(op, r[19] & r[20]);
        end
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
